/* File: logic/ctb_pkg.sv */
// constants shared by the transmit buffer controller
package ctb_pkg;
	// ---------------------------------------------------------------
	// register byte offsets (per-buffer arrays are 16 words each)
	// ---------------------------------------------------------------
	localparam logic [8:0] OFS_CTRL = 9'h000; // txbuf_control[0..15]
	localparam logic [8:0] OFS_STAT = 9'h040; // txbuf_status[0..15]
	localparam logic [8:0] OFS_ID = 9'h080; // txbuf_identifier_reg[0..15]
	localparam logic [8:0] OFS_PTR = 9'h0c0; // txbuf_pointer_reg[0..15]
	localparam logic [8:0] OFS_DATA = 9'h100; // txbuf_payload_reg[0..15]
	localparam logic [8:0] OFS_CHAN = 9'h140; // channel_control
	localparam logic [8:0] OFS_IE = 9'h144; // tx_complete_irq_enable_reg
	localparam logic [8:0] OFS_HIST = 9'h148; // history_config
	localparam logic [8:0] OFS_REQ_SUM = 9'h14c; // tx_request_summary
	localparam logic [8:0] OFS_ABT_SUM = 9'h150; // tx_abort_request_summary
	localparam logic [8:0] OFS_CMP_SUM = 9'h154; // tx_complete_summary
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CTRL_REQ = 0; // tx_request_bit
	localparam int CTRL_ABT = 1; // tx_abort_request_bit
	localparam int CTRL_OS = 2; // one_shot_bit
	localparam int STAT_PEND = 0; // tx_request_pending
	localparam int STAT_RES = 1; // tx_result_code low bit, two bits
	localparam int ID_HIST = 29; // history_store_bit
	localparam int PTR_DLC = 28; // length code low bit, four bits
	localparam int CHAN_MODE = 0; // mode low bit, two bits
	localparam int CHAN_AIE = 2; // abort_irq_enable
	localparam int HIST_DE = 0; // history_data_enable
	localparam int HIST_EN = 1; // history_enable
	// ---------------------------------------------------------------
	// encodings and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0] RES_NONE = 2'h0;
	localparam logic [1:0] RES_ABORT = 2'h1;
	localparam logic [1:0] RES_OK = 2'h2;
	localparam logic [1:0] RES_OK_ABT = 2'h3;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [1:0] MODE_COMM = 2'h1;
	localparam logic [1:0] MODE_STBY = 2'h2;
	localparam logic [1:0] MODE_RST_VAL = MODE_RESET;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_OFFER = 2'h1,
		ST_BUSY = 2'h3
	} ctb_st_t;
endpackage : ctb_pkg

/* File: logic/ctb_tx_buffers.sv */
// transmit buffer array with request, abort and one-shot control
//
// Behaviour
// - sixteen transmit buffers per channel, any usage
// - zeroed control leaves buffer flags untouched
// - request bit set sends the stored frame
// - success gives code 10, or 11 if aborting
// - per-buffer completion interrupt enable bit
// - data label valid only when history enabled
// - arbitration loss retries, one-shot aborts instead
// - in-flight or offered abort waits loss/error, others immediate
// - abort done gives code 01, clears pending
// - success despite abort request reports code 11
// - code 11 raises completion, not abort interrupt
// - one-shot loss or error reports 01, no retry
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module ctb_tx_buffers #(
	parameter int NB = 16 // buffers on this channel
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [8:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic eng_start_i, // engine took the offered frame
	input wire logic eng_ok_i, // frame sent without loss or error
	input wire logic eng_arb_lost_i, // arbitration lost
	input wire logic eng_error_i, // bus error during frame
	output logic tx_valid_o,
	output logic [3:0] tx_buf_o,
	output logic [28:0] tx_id_o,
	output logic [3:0] tx_dlc_o,
	output logic [31:0] tx_payload_o,
	output logic [15:0] tx_label_o,
	output logic tx_hist_o,
	output logic tx_one_shot_o,
	output logic irq_complete_o,
	output logic irq_abort_o
);
	// ---------------------------------------------------------------
	// elaboration check and state
	// ---------------------------------------------------------------
	// address map leaves room for sixteen slots per array
	if (NB < 1 || NB > 16) begin : g_bad_nb
		$error("NB must be 1 to 16");
	end
	localparam logic [4:0] NB_W = 5'(NB);

	typedef struct packed {
		logic [NB-1:0] req; // tx_request_bit, also pending flag
		logic [NB-1:0] abt; // tx_abort_request_bit
		logic [NB-1:0] os; // one_shot_bit
		logic [NB-1:0][1:0] res; // tx_result_code
		logic [NB-1:0][28:0] id; // frame_identifier
		logic [NB-1:0] hst; // history_store_bit
		logic [NB-1:0][31:0] ptr; // length code and data label
		logic [NB-1:0][31:0] pay; // payload word
		logic [NB-1:0] ie; // tx_complete_irq_enable
		logic [1:0] mode; // channel mode
		logic aie; // abort_irq_enable
		logic hde; // history_data_enable
		logic hen; // history_enable
		ctb_pkg::ctb_st_t st; // scheduler state
		logic [3:0] cur; // buffer offered or in flight
		logic [31:0] rdata;
		logic tx_valid;
		logic [28:0] tx_id;
		logic [3:0] tx_dlc;
		logic [31:0] tx_pay;
		logic [15:0] tx_label;
		logic tx_hist;
		logic tx_os;
		logic irq_c;
		logic irq_a;
	} ctb_state_t;

	ctb_state_t s_r; // all registered state
	ctb_state_t s_nxt; // next value
	logic [3:0] widx; // buffer slot addressed
	logic idx_ok; // slot exists
	logic mode_ok; // communication or standby mode
	logic [3:0] sel; // lowest ready buffer
	logic any_rdy; // some buffer may be offered

	assign widx = addr_i[5:2];
	assign idx_ok = {1'b0, widx} < NB_W;
	assign mode_ok = s_r.mode == ctb_pkg::MODE_COMM || s_r.mode == ctb_pkg::MODE_STBY;

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = '0;
		s_nxt.irq_c = 1'b0;
		s_nxt.irq_a = 1'b0;
		sel = '0;
		any_rdy = 1'b0;
		// register writes; hardware updates below override them
		if (wr_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_CTRL[8:6]) begin
			// control ignored outside communication/standby mode
			if (mode_ok) begin
				if (wdata_i[ctb_pkg::CTRL_REQ] && !s_r.req[widx]
						&& s_r.res[widx] == ctb_pkg::RES_NONE) begin
					s_nxt.req[widx] = 1'b1;
					s_nxt.os[widx] = wdata_i[ctb_pkg::CTRL_OS];
				end
				// abort only sticks on a pending buffer
				if (wdata_i[ctb_pkg::CTRL_ABT] && s_r.req[widx]) begin
					s_nxt.abt[widx] = 1'b1;
				end
			end
		end else if (wr_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_STAT[8:6]) begin
			// only a write of 00 clears the result code
			if (mode_ok && wdata_i[ctb_pkg::STAT_RES +: 2] == ctb_pkg::RES_NONE) begin
				s_nxt.res[widx] = ctb_pkg::RES_NONE;
			end
		end else if (wr_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_ID[8:6]) begin
			s_nxt.id[widx] = wdata_i[28:0];
			s_nxt.hst[widx] = wdata_i[ctb_pkg::ID_HIST];
		end else if (wr_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_PTR[8:6]) begin
			s_nxt.ptr[widx] = wdata_i;
		end else if (wr_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_DATA[8:6]) begin
			s_nxt.pay[widx] = wdata_i;
		end else if (wr_i && addr_i == ctb_pkg::OFS_CHAN) begin
			s_nxt.mode = wdata_i[ctb_pkg::CHAN_MODE +: 2];
			s_nxt.aie = wdata_i[ctb_pkg::CHAN_AIE];
		end else if (wr_i && addr_i == ctb_pkg::OFS_IE) begin
			s_nxt.ie = wdata_i[NB-1:0];
		end else if (wr_i && addr_i == ctb_pkg::OFS_HIST) begin
			s_nxt.hde = wdata_i[ctb_pkg::HIST_DE];
			s_nxt.hen = wdata_i[ctb_pkg::HIST_EN];
		end
		// register reads, data stands one cycle only
		if (rd_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_CTRL[8:6]) begin
			s_nxt.rdata = {29'h0, s_r.os[widx], s_r.abt[widx], s_r.req[widx]};
		end else if (rd_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_STAT[8:6]) begin
			s_nxt.rdata = {29'h0, s_r.res[widx], s_r.req[widx]};
		end else if (rd_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_ID[8:6]) begin
			s_nxt.rdata = {2'h0, s_r.hst[widx], s_r.id[widx]};
		end else if (rd_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_PTR[8:6]) begin
			s_nxt.rdata = s_r.ptr[widx];
		end else if (rd_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_DATA[8:6]) begin
			s_nxt.rdata = s_r.pay[widx];
		end else if (rd_i && addr_i == ctb_pkg::OFS_CHAN) begin
			s_nxt.rdata = {29'h0, s_r.aie, s_r.mode};
		end else if (rd_i && addr_i == ctb_pkg::OFS_IE) begin
			s_nxt.rdata = 32'(s_r.ie);
		end else if (rd_i && addr_i == ctb_pkg::OFS_HIST) begin
			s_nxt.rdata = {30'h0, s_r.hen, s_r.hde};
		end else if (rd_i && addr_i == ctb_pkg::OFS_REQ_SUM) begin
			s_nxt.rdata = 32'(s_r.req);
		end else if (rd_i && addr_i == ctb_pkg::OFS_ABT_SUM) begin
			s_nxt.rdata = 32'(s_r.abt);
		end else if (rd_i && addr_i == ctb_pkg::OFS_CMP_SUM) begin
			for (int i = 0; i < NB; i++) begin
				s_nxt.rdata[i] = s_r.res[i][1];
			end
		end
		// lowest index wins; aborting buffers are never offered
		for (int i = NB - 1; i >= 0; i--) begin
			if (s_r.req[i] && !s_r.abt[i]) begin
				sel = 4'(i);
				any_rdy = 1'b1;
			end
		end
		// scheduler
		case (s_r.st)
			ctb_pkg::ST_IDLE: begin
				// a zeroed control never raises req, so such a buffer stays quiet
				if (any_rdy && s_r.mode == ctb_pkg::MODE_COMM) begin
					s_nxt.st = ctb_pkg::ST_OFFER;
					s_nxt.cur = sel;
					s_nxt.tx_valid = 1'b1;
					s_nxt.tx_id = s_r.id[sel];
					s_nxt.tx_dlc = s_r.ptr[sel][ctb_pkg::PTR_DLC +: 4];
					s_nxt.tx_pay = s_r.pay[sel];
					s_nxt.tx_hist = s_r.hst[sel] & s_r.hde & s_r.hen;
					s_nxt.tx_label = (s_r.hst[sel] & s_r.hde & s_r.hen) ?
						s_r.ptr[sel][15:0] : 16'h0;
					s_nxt.tx_os = s_r.os[sel];
				end
			end
			ctb_pkg::ST_OFFER: begin
				// the chosen-next frame keeps its abort until it ends
				if (eng_start_i) begin
					s_nxt.st = ctb_pkg::ST_BUSY;
					s_nxt.tx_valid = 1'b0;
				end
			end
			ctb_pkg::ST_BUSY: begin
				if (eng_ok_i) begin
					// success wins over a late abort request
					s_nxt.res[s_r.cur] = s_r.abt[s_r.cur] ?
						ctb_pkg::RES_OK_ABT : ctb_pkg::RES_OK;
					s_nxt.req[s_r.cur] = 1'b0;
					s_nxt.abt[s_r.cur] = 1'b0;
					s_nxt.os[s_r.cur] = 1'b0;
					s_nxt.irq_c = s_r.ie[s_r.cur];
					s_nxt.st = ctb_pkg::ST_IDLE;
				end else if (eng_arb_lost_i || eng_error_i) begin
					s_nxt.st = ctb_pkg::ST_IDLE;
					// normal frames stay pending and are re-offered
					if (s_r.abt[s_r.cur] || s_r.os[s_r.cur]) begin
						s_nxt.res[s_r.cur] = ctb_pkg::RES_ABORT;
						s_nxt.req[s_r.cur] = 1'b0;
						s_nxt.abt[s_r.cur] = 1'b0;
						s_nxt.os[s_r.cur] = 1'b0;
						s_nxt.irq_a = s_r.aie;
					end
				end
			end
			default: begin
				s_nxt.st = ctb_pkg::ST_IDLE;
			end
		endcase
		// buffers neither offered nor on the bus abort at once
		for (int i = 0; i < NB; i++) begin
			if (s_r.req[i] && s_r.abt[i]
					&& !(s_r.st != ctb_pkg::ST_IDLE && s_r.cur == 4'(i))) begin
				s_nxt.res[i] = ctb_pkg::RES_ABORT;
				s_nxt.req[i] = 1'b0;
				s_nxt.abt[i] = 1'b0;
				s_nxt.os[i] = 1'b0;
				s_nxt.irq_a = s_r.aie;
			end
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.mode <= ctb_pkg::MODE_RST_VAL;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata_o = s_r.rdata;
	assign tx_valid_o = s_r.tx_valid;
	assign tx_buf_o = s_r.cur;
	assign tx_id_o = s_r.tx_id;
	assign tx_dlc_o = s_r.tx_dlc;
	assign tx_payload_o = s_r.tx_pay;
	assign tx_label_o = s_r.tx_label;
	assign tx_hist_o = s_r.tx_hist;
	assign tx_one_shot_o = s_r.tx_os;
	assign irq_complete_o = s_r.irq_c;
	assign irq_abort_o = s_r.irq_a;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic busy_ok; // frame in flight ended well
	logic busy_bad; // frame in flight lost or failed
	assign busy_ok = s_r.st == ctb_pkg::ST_BUSY && eng_ok_i;
	assign busy_bad = s_r.st == ctb_pkg::ST_BUSY && !eng_ok_i
		&& (eng_arb_lost_i || eng_error_i);

	sequence s_req_write;
		wr_i && idx_ok && addr_i[8:6] == ctb_pkg::OFS_CTRL[8:6]
			&& wdata_i[ctb_pkg::CTRL_REQ] && !wdata_i[ctb_pkg::CTRL_ABT]
			&& s_r.res[widx] == ctb_pkg::RES_NONE && s_r.req == '0
			&& s_r.st == ctb_pkg::ST_IDLE && s_r.mode == ctb_pkg::MODE_COMM;
	endsequence
	sequence s_offer;
		tx_valid_o && tx_buf_o == $past(widx, 2);
	endsequence

	a_req_offer: assert property (s_req_write |-> ##2 s_offer)
		else $error("request not offered two cycles later");
	a_ok_plain: assert property (busy_ok && !s_r.abt[s_r.cur]
		|=> s_r.res[$past(s_r.cur)] == ctb_pkg::RES_OK)
		else $error("success without abort did not give 10");
	a_ok_aborted: assert property (busy_ok && s_r.abt[s_r.cur]
		|=> s_r.res[$past(s_r.cur)] == ctb_pkg::RES_OK_ABT)
		else $error("success with abort did not give 11");
	a_retry_keep: assert property (busy_bad && !s_r.abt[s_r.cur] && !s_r.os[s_r.cur]
		|=> s_r.req[$past(s_r.cur)] && s_r.st == ctb_pkg::ST_IDLE)
		else $error("lost frame was not kept pending");
	a_oneshot_end: assert property (busy_bad && s_r.os[s_r.cur]
		|=> !s_r.req[$past(s_r.cur)] && s_r.res[$past(s_r.cur)] == ctb_pkg::RES_ABORT)
		else $error("one-shot loss did not end with 01");
	a_abort_wait: assert property (s_r.st == ctb_pkg::ST_BUSY && s_r.abt[s_r.cur]
		&& !eng_ok_i && !eng_arb_lost_i && !eng_error_i
		|=> s_r.req[$past(s_r.cur)])
		else $error("in-flight frame aborted before loss or error");
	a_abort_now: assert property (s_r.req[widx] && !s_r.abt[widx] && wr_i && idx_ok
		&& addr_i[8:6] == ctb_pkg::OFS_CTRL[8:6] && wdata_i[ctb_pkg::CTRL_ABT]
		&& mode_ok && s_r.st != ctb_pkg::ST_IDLE && s_r.cur != widx
		|-> ##2 s_r.res[$past(widx, 2)] == ctb_pkg::RES_ABORT
		&& !s_r.req[$past(widx, 2)])
		else $error("waiting buffer not aborted at once");
	a_irq_pick: assert property (busy_ok
		|=> irq_complete_o == $past(s_r.ie[s_r.cur]) && !irq_abort_o)
		else $error("wrong interrupt on completion");
	a_label_gate: assert property (tx_valid_o && !tx_hist_o |-> tx_label_o == 16'h0)
		else $error("data label passed without history storage");
endmodule : ctb_tx_buffers

/* File: verification/ctb_bus_model.sv */
// behavioural protocol engine and shared bus facing the transmit buffers
`timescale 1ns/1ns
module ctb_bus_model #(
	parameter int FRAME = 8 // one less than the cycles a frame occupies the bus
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic offer, // frame offered by the buffers
	input wire logic slow, // stall before taking the frame
	input wire logic [1:0] outcome, // 0 ok, 1 lost, 2 error, 3 lost once then ok
	output logic start,
	output logic ok,
	output logic lost,
	output logic err
);
	// ---------------------------------------------------------------
	// frame sequencer
	// ---------------------------------------------------------------
	logic [1:0] st_r; // 0 idle, 1 before start, 2 on the bus
	logic [3:0] cnt_r; // cycles left in this phase
	logic lost_once_r; // mode 3 already gave its loss
	// pulses last one cycle; exactly one end pulse follows each start
	always @(posedge clk) begin
		start <= 1'b0;
		ok <= 1'b0;
		lost <= 1'b0;
		err <= 1'b0;
		if (!rst_n) begin
			st_r <= 2'h0;
			cnt_r <= 4'h0;
			lost_once_r <= 1'b0;
		end else if (st_r == 2'h0) begin
			// a new offer is only looked at while idle
			if (offer) begin
				st_r <= 2'h1;
				cnt_r <= slow ? 4'h8 : 4'h0;
			end
			if (outcome != 2'h3) lost_once_r <= 1'b0;
		end else if (st_r == 2'h1) begin
			// take the frame while it still stands offered
			if (cnt_r == 4'h0) begin
				start <= 1'b1;
				st_r <= 2'h2;
				cnt_r <= 4'(FRAME);
			end else cnt_r <= cnt_r - 4'h1;
		end else if (cnt_r == 4'h0) begin
			// end of frame: the bus decides the outcome
			st_r <= 2'h0;
			case (outcome)
				2'h0: ok <= 1'b1;
				2'h1: lost <= 1'b1;
				2'h2: err <= 1'b1;
				default: begin
					// lose once so the retry is seen, then win
					ok <= lost_once_r;
					lost <= !lost_once_r;
					lost_once_r <= 1'b1;
				end
			endcase
		end else cnt_r <= cnt_r - 4'h1;
	end
endmodule : ctb_bus_model

/* File: verification/can_tx_buffer_request_abort_test.sv */
// self-checking bench for the transmit buffer controller
`timescale 1ns/1ns
module can_tx_buffer_request_abort_test;
	// ---------------------------------------------------------------
	// signals and counters
	// ---------------------------------------------------------------
	logic clk, rst_n, wr_s, rd_s, slow;
	logic [8:0] addr;
	logic [31:0] wdata, rdata;
	logic start, ok, lost, err, tx_valid, irq_c, irq_a;
	logic [3:0] tx_buf, seen_buf;
	logic [28:0] tx_id, seen_id;
	logic [15:0] label, seen_label;
	logic [3:0] tx_dlc, seen_dlc;
	logic [31:0] tx_pay, seen_pay;
	logic tx_hist, seen_hist, tx_os, seen_os;
	logic [1:0] outcome;
	int mismatches, n_checks, n_cmp, n_abt, n_start, c0, a0, s0;
	ctb_tx_buffers u_dut (.clk(clk), .rst_n(rst_n), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .eng_start_i(start), .eng_ok_i(ok),
		.eng_arb_lost_i(lost), .eng_error_i(err), .tx_valid_o(tx_valid), .tx_buf_o(tx_buf),
		.tx_id_o(tx_id), .tx_dlc_o(tx_dlc), .tx_payload_o(tx_pay), .tx_label_o(label),
		.tx_hist_o(tx_hist), .tx_one_shot_o(tx_os), .irq_complete_o(irq_c),
		.irq_abort_o(irq_a));
	ctb_bus_model u_bus (.clk(clk), .rst_n(rst_n), .offer(tx_valid), .slow(slow),
		.outcome(outcome), .start(start), .ok(ok), .lost(lost), .err(err));
	// clock at 250 MHz
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// sampled mid-cycle so registered outputs have settled
	always @(negedge clk) begin
		if (irq_c === 1'b1) n_cmp++;
		if (irq_a === 1'b1) n_abt++;
		if (start === 1'b1 && tx_valid === 1'b1) begin
			n_start++;
			seen_buf = tx_buf;
			seen_id = tx_id;
			seen_label = label;
			seen_dlc = tx_dlc;
			seen_pay = tx_pay;
			seen_hist = tx_hist;
			seen_os = tx_os;
		end
	end
	// ---------------------------------------------------------------
	// bus helpers
	// ---------------------------------------------------------------
	function automatic logic [8:0] ra(input logic [8:0] base, input logic [3:0] i);
		return base + {3'h0, i, 2'h0};
	endfunction : ra
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [8:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic chk_rd(input string w, input logic [8:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(w, e, d);
	endtask : chk_rd
	task automatic chk_st(input logic [3:0] i, input logic [1:0] res);
		chk_rd("status", ra(ctb_pkg::OFS_STAT, i), {29'h0, res, 1'b0});
	endtask : chk_st
	task automatic print_verdict();
		if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	// bounded poll until the buffer is no longer pending
	task automatic wait_done(input logic [3:0] i);
		logic [31:0] d;
		d = 32'h1;
		for (int k = 0; k < 60 && d[0] !== 1'b0; k++) rd(ra(ctb_pkg::OFS_STAT, i), d);
		if (d[0] !== 1'b0) begin
			mismatches++;
			$display("CHECK FAILED pending expected 0 seen %h", d[0]);
			print_verdict();
		end
	endtask : wait_done
	task automatic setup(input logic [1:0] o, input logic s);
		@(posedge clk);
		outcome <= o;
		slow <= s;
		c0 = n_cmp;
		a0 = n_abt;
		s0 = n_start;
	endtask : setup
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic sc_reset();
		chk_rd("ctrl0", ra(ctb_pkg::OFS_CTRL, 4'h0), 32'h0);
		chk_st(4'hf, ctb_pkg::RES_NONE);
		chk_rd("unmapped", 9'h1fc, 32'h0);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h2), 32'h1);
		chk_st(4'h2, ctb_pkg::RES_NONE);
		wr(ctb_pkg::OFS_CHAN, 32'h4 | 32'(ctb_pkg::MODE_COMM));
		wr(ctb_pkg::OFS_IE, 32'h000a);
	endtask : sc_reset
	task automatic sc_send();
		setup(2'h0, 1'b0);
		wr(ra(ctb_pkg::OFS_ID, 4'h3), 32'h0000_0123);
		wr(ra(ctb_pkg::OFS_PTR, 4'h3), 32'h8000_abcd);
		wr(ra(ctb_pkg::OFS_DATA, 4'h3), 32'hc0de_5a17);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h3), 32'h1);
		wait_done(4'h3);
		chk_st(4'h3, ctb_pkg::RES_OK);
		chk("buffer", 32'h3, 32'(seen_buf));
		chk("identifier", 32'h123, 32'(seen_id));
		chk("label off", 32'h0, 32'(seen_label));
		chk("length code", 32'h8, 32'(seen_dlc));
		chk("payload", 32'hc0de_5a17, seen_pay);
		chk("history off", 32'h0, 32'(seen_hist));
		chk("one-shot off", 32'h0, 32'(seen_os));
		chk("done irq", 32'(c0 + 1), 32'(n_cmp));
		wr(ra(ctb_pkg::OFS_CTRL, 4'h3), 32'h1);
		wr(ra(ctb_pkg::OFS_STAT, 4'h3), 32'h6);
		chk_st(4'h3, ctb_pkg::RES_OK);
		chk("starts", 32'(s0 + 1), 32'(n_start));
		wr(ra(ctb_pkg::OFS_STAT, 4'h3), 32'h0);
		chk_st(4'h3, ctb_pkg::RES_NONE);
	endtask : sc_send
	task automatic sc_retry();
		setup(2'h3, 1'b0);
		wr(ctb_pkg::OFS_HIST, 32'h3);
		wr(ra(ctb_pkg::OFS_ID, 4'h4), 32'h2000_0000);
		wr(ra(ctb_pkg::OFS_PTR, 4'h4), 32'h0000_5a5a);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h4), 32'h1);
		wait_done(4'h4);
		chk_st(4'h4, ctb_pkg::RES_OK);
		chk("attempts", 32'(s0 + 2), 32'(n_start));
		chk("label on", 32'h5a5a, 32'(seen_label));
		chk("history on", 32'h1, 32'(seen_hist));
		chk("masked irq", 32'(c0), 32'(n_cmp));
	endtask : sc_retry
	task automatic sc_one_shot();
		setup(2'h1, 1'b0);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h6), 32'h5);
		wait_done(4'h6);
		repeat (12) @(posedge clk);
		chk_st(4'h6, ctb_pkg::RES_ABORT);
		chk("no retry", 32'(s0 + 1), 32'(n_start));
		chk("one-shot on", 32'h1, 32'(seen_os));
		chk("abort irq", 32'(a0 + 1), 32'(n_abt));
	endtask : sc_one_shot
	task automatic sc_abort();
		setup(2'h0, 1'b1);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h1), 32'h1);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h5), 32'h1);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h5), 32'h3);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h1), 32'h3);
		chk_st(4'h5, ctb_pkg::RES_ABORT);
		wait_done(4'h1);
		chk_st(4'h1, ctb_pkg::RES_OK_ABT);
		chk("one start", 32'(s0 + 1), 32'(n_start));
		chk("done irq", 32'(c0 + 1), 32'(n_cmp));
		chk("abort irq", 32'(a0 + 1), 32'(n_abt));
	endtask : sc_abort
	// standby accepts control writes but never offers a frame
	task automatic sc_standby();
		setup(2'h0, 1'b0);
		wr(ctb_pkg::OFS_CHAN, 32'h4 | 32'(ctb_pkg::MODE_STBY));
		wr(ra(ctb_pkg::OFS_CTRL, 4'h8), 32'h1);
		chk_rd("standby ctrl", ra(ctb_pkg::OFS_CTRL, 4'h8), 32'h1);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h8), 32'h3);
		chk_st(4'h8, ctb_pkg::RES_ABORT);
		chk("standby starts", 32'(s0), 32'(n_start));
		chk("standby abort irq", 32'(a0 + 1), 32'(n_abt));
		wr(ctb_pkg::OFS_CHAN, 32'h4 | 32'(ctb_pkg::MODE_COMM));
	endtask : sc_standby
	task automatic sc_abort_err();
		setup(2'h2, 1'b0);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h7), 32'h1);
		wr(ra(ctb_pkg::OFS_CTRL, 4'h7), 32'h3);
		wait_done(4'h7);
		chk_st(4'h7, ctb_pkg::RES_ABORT);
		chk("abort irq", 32'(a0 + 1), 32'(n_abt));
		chk("no done irq", 32'(c0), 32'(n_cmp));
		chk_rd("req sum", ctb_pkg::OFS_REQ_SUM, 32'h0);
		chk_rd("cmp sum", ctb_pkg::OFS_CMP_SUM, 32'h12);
	endtask : sc_abort_err
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_n, wr_s, rd_s, slow, addr, wdata, outcome} = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		sc_reset();
		sc_send();
		sc_retry();
		sc_one_shot();
		sc_abort();
		sc_standby();
		sc_abort_err();
		print_verdict();
	end
endmodule : can_tx_buffer_request_abort_test
